/* File: logic/can_transceiver_mode_wake_control.sv */
`timescale 1ns/10ps
// How it works
// - separate detectors on both supplies; mode logic reset until both valid.
// - bus high impedance until main supply above undervoltage; again on falling below.
// - normal mode with main undervoltage forces receive output recessive.
// - standby low-power receiver on while supplies above power-on low; passes bus data only after a wake event.
// - unpowered at power-up or when either supply drops below power-on low.
// - unpowered: bus biased to ground via high impedance; no transmit, receive, wake.
// - unpowered to wake once both supplies above power-on high.
// - normal falls to wake on main undervoltage low or bandgap lost.
// - standby goes to wake when standby select goes low.
// - wake mode: bus to ground, drivers off, receive output high.
// - wake to normal needs undervoltage high ok, bandgap ok, transmit high.
// - normal: slope drivers on, bus at half supply, fast receiver on.
// - standby select high enters standby: low-power receiver and wake block on.
// - standby holds receive high until wake event, then passes bus data on it (low while dominant).
// - basic variant wakes on one dominant phase of at least filter time.
// - pattern variant needs dominant, recessive, dominant, each at least filter time.
// - pattern not complete within timeout resets the detector.
// - wake detection only while both supplies valid.
// - basic filter accepts dominant no later than 3.6 us.
// - receive output low for dominant, high for recessive when passing data.
module can_transceiver_mode_wake_control #(
  parameter bit PATTERN_WAKE = 1'b0,
  parameter int TIMEOUT_LIMIT = xcvr_mode_pkg::TIMEOUT_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic main_por_high_in,
  input wire logic main_por_low_ok_in,
  input wire logic io_por_high_in,
  input wire logic io_por_low_ok_in,
  input wire logic main_uv_high_in,
  input wire logic main_uv_low_ok_in,
  input wire logic bandgap_ok_in,
  input wire logic txd_in,
  input wire logic standby_select_in,
  input wire logic bus_dominant_in,
  output logic [1:0] mode_out,
  output logic bus_hiz_out,
  output logic bias_half_out,
  output logic bias_ground_out,
  output logic driver_en_out,
  output logic drive_dominant_out,
  output logic hs_rx_en_out,
  output logic lp_rx_en_out,
  output logic wake_en_out,
  output logic wake_event_out,
  output logic rxd_out
);
  // every pin input passes two flops before any logic reads it
  logic [10:0] meta_r;
  logic [10:0] sync_r;
  logic [10:0] raw;
  logic mpor_h, mpor_l, ipor_h, ipor_l, uvh, uvl, bg, txd, standby_select, dom, supplies_ok;

  assign raw = {main_por_high_in, main_por_low_ok_in, io_por_high_in, io_por_low_ok_in,
                main_uv_high_in, main_uv_low_ok_in, bandgap_ok_in, txd_in,
                standby_select_in, bus_dominant_in, 1'b0};

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= 11'h000;
      sync_r <= 11'h000;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  assign {mpor_h, mpor_l, ipor_h, ipor_l, uvh, uvl, bg, txd, standby_select, dom} = sync_r[10:1];
  assign supplies_ok = mpor_l && ipor_l;

  xcvr_mode_pkg::mode_e mode_r, mode_nxt;
  xcvr_mode_pkg::wake_e wk_r, wk_nxt;
  logic phase_met, timed_out, wk_active;
  logic [xcvr_mode_pkg::CNT_W-1:0] to_cnt_r;
  logic bus_up_r;
  logic dom_d_r;
  logic phase_ok;

  // the timer's flag is one edge old; block it on the edge where the level just flipped
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dom_d_r <= 1'b0;
    end else begin
      dom_d_r <= dom;
    end
  end
  assign phase_ok = phase_met && dom == dom_d_r;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      xcvr_mode_pkg::MODE_UNPOWERED: begin
        if (mpor_h && ipor_h) begin
          mode_nxt = xcvr_mode_pkg::MODE_WAKE;
        end
      end
      xcvr_mode_pkg::MODE_WAKE: begin
        if (standby_select) begin
          mode_nxt = xcvr_mode_pkg::MODE_STANDBY;
        end else if (uvh && bg && txd) begin
          mode_nxt = xcvr_mode_pkg::MODE_NORMAL;
        end
      end
      xcvr_mode_pkg::MODE_NORMAL: begin
        if (!uvl || !bg) begin
          mode_nxt = xcvr_mode_pkg::MODE_WAKE;
        end else if (standby_select) begin
          mode_nxt = xcvr_mode_pkg::MODE_STANDBY;
        end
      end
      xcvr_mode_pkg::MODE_STANDBY: begin
        if (!standby_select) begin
          mode_nxt = xcvr_mode_pkg::MODE_WAKE;
        end
      end
      default: mode_nxt = xcvr_mode_pkg::MODE_UNPOWERED;
    endcase
    if (!supplies_ok) begin
      mode_nxt = xcvr_mode_pkg::MODE_UNPOWERED;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= xcvr_mode_pkg::MODE_UNPOWERED;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // bus stays disconnected from power-up until the main supply clears undervoltage
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_up_r <= 1'b0;
    end else if (!supplies_ok || !uvl) begin
      bus_up_r <= 1'b0;
    end else if (uvh) begin
      bus_up_r <= 1'b1;
    end
  end

  // wake detector runs only in standby with both supplies valid
  assign wk_active = mode_r == xcvr_mode_pkg::MODE_STANDBY && supplies_ok;

  phase_timer #(
    .W(xcvr_mode_pkg::CNT_W)
  ) u_phase (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clear_in(!wk_active),
    .level_in(dom),
    .limit_in(xcvr_mode_pkg::CNT_W'(xcvr_mode_pkg::FILTER_CYCLES)),
    .reached_out(phase_met)
  );

  // timeout spans the whole pattern, started by the first dominant
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      to_cnt_r <= '0;
    end else if (!wk_active || wk_r == xcvr_mode_pkg::WK_IDLE || wk_r == xcvr_mode_pkg::WK_DONE) begin
      to_cnt_r <= '0;
    end else if (!timed_out) begin
      to_cnt_r <= to_cnt_r + {{(xcvr_mode_pkg::CNT_W-1){1'b0}}, 1'b1};
    end
  end
  assign timed_out = PATTERN_WAKE && to_cnt_r >= xcvr_mode_pkg::CNT_W'(TIMEOUT_LIMIT);

  always_comb begin
    wk_nxt = wk_r;
    case (wk_r)
      xcvr_mode_pkg::WK_IDLE: begin
        if (dom) begin
          wk_nxt = xcvr_mode_pkg::WK_DOM1;
        end
      end
      xcvr_mode_pkg::WK_DOM1: begin
        if (!dom) begin
          wk_nxt = xcvr_mode_pkg::WK_IDLE;
        end else if (phase_ok) begin
          wk_nxt = PATTERN_WAKE ? xcvr_mode_pkg::WK_REC : xcvr_mode_pkg::WK_DONE;
        end
      end
      xcvr_mode_pkg::WK_REC: begin
        // a long dominant before the recessive is fine; a recessive then needs its own filter
        if (!dom && phase_ok) begin
          wk_nxt = xcvr_mode_pkg::WK_DOM2;
        end
      end
      xcvr_mode_pkg::WK_DOM2: begin
        if (dom && phase_ok) begin
          wk_nxt = xcvr_mode_pkg::WK_DONE;
        end
      end
      xcvr_mode_pkg::WK_DONE: wk_nxt = xcvr_mode_pkg::WK_DONE;
      default: wk_nxt = xcvr_mode_pkg::WK_IDLE;
    endcase
    if (wk_r != xcvr_mode_pkg::WK_DONE && wk_nxt != xcvr_mode_pkg::WK_DONE && timed_out) begin
      wk_nxt = xcvr_mode_pkg::WK_IDLE;
    end
    if (!wk_active) begin
      wk_nxt = xcvr_mode_pkg::WK_IDLE;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wk_r <= xcvr_mode_pkg::WK_IDLE;
    end else begin
      wk_r <= wk_nxt;
    end
  end

  // output stage: all registered
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode_out <= 2'h0;
      bus_hiz_out <= 1'b1;
      bias_half_out <= 1'b0;
      bias_ground_out <= 1'b1;
      driver_en_out <= 1'b0;
      drive_dominant_out <= 1'b0;
      hs_rx_en_out <= 1'b0;
      lp_rx_en_out <= 1'b0;
      wake_en_out <= 1'b0;
      wake_event_out <= 1'b0;
      rxd_out <= xcvr_mode_pkg::RXD_RECESSIVE;
    end else begin
      mode_out <= mode_r;
      bus_hiz_out <= mode_r == xcvr_mode_pkg::MODE_UNPOWERED || !bus_up_r;
      bias_half_out <= mode_r == xcvr_mode_pkg::MODE_NORMAL && bus_up_r;
      bias_ground_out <= mode_r != xcvr_mode_pkg::MODE_NORMAL;
      driver_en_out <= mode_r == xcvr_mode_pkg::MODE_NORMAL && bus_up_r;
      drive_dominant_out <= mode_r == xcvr_mode_pkg::MODE_NORMAL && bus_up_r && !txd;
      hs_rx_en_out <= mode_r == xcvr_mode_pkg::MODE_NORMAL;
      lp_rx_en_out <= mode_r == xcvr_mode_pkg::MODE_STANDBY;
      wake_en_out <= wk_active;
      wake_event_out <= wk_r == xcvr_mode_pkg::WK_DONE;
      case (mode_r)
        xcvr_mode_pkg::MODE_NORMAL:
          rxd_out <= !uvl ? xcvr_mode_pkg::RXD_RECESSIVE : !dom;
        xcvr_mode_pkg::MODE_STANDBY:
          rxd_out <= wk_r == xcvr_mode_pkg::WK_DONE ? !dom : xcvr_mode_pkg::RXD_RECESSIVE;
        default: rxd_out <= xcvr_mode_pkg::RXD_RECESSIVE;
      endcase
    end
  end

  AST_UNPOWERED_ON_LOSS: assert property (@(posedge clock_in) disable iff (rst_in)
    !supplies_ok |=> mode_r == xcvr_mode_pkg::MODE_UNPOWERED) else $error("no unpowered on supply loss");
  AST_POR_TO_WAKE: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_UNPOWERED && mpor_h && ipor_h && supplies_ok
    |=> mode_r == xcvr_mode_pkg::MODE_WAKE) else $error("unpowered did not go to wake");
  AST_NORMAL_GUARD: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_WAKE ##1 mode_r == xcvr_mode_pkg::MODE_NORMAL
    |-> $past(uvh) && $past(bg) && $past(txd)) else $error("normal entered without conditions");
  AST_NORMAL_FALLBACK: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_NORMAL && supplies_ok && (!uvl || !bg)
    |=> mode_r == xcvr_mode_pkg::MODE_WAKE) else $error("normal did not fall back");
  AST_STANDBY_EXIT: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_STANDBY && !standby_select && supplies_ok
    |=> mode_r == xcvr_mode_pkg::MODE_WAKE) else $error("standby did not exit");
  AST_WAKE_RXD_HIGH: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_WAKE |=> rxd_out && !driver_en_out && bias_ground_out)
    else $error("wake mode outputs wrong");
  AST_UV_RXD: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_NORMAL && !uvl |=> rxd_out) else $error("rxd not forced");
  AST_HIZ_UV: assert property (@(posedge clock_in) disable iff (rst_in)
    !uvl |=> ##1 bus_hiz_out && !driver_en_out) else $error("bus not high impedance");
  AST_STANDBY_RXD: assert property (@(posedge clock_in) disable iff (rst_in)
    mode_r == xcvr_mode_pkg::MODE_STANDBY && wk_r != xcvr_mode_pkg::WK_DONE |=> rxd_out)
    else $error("rxd low before wake");
  AST_NO_WAKE_INACTIVE: assert property (@(posedge clock_in) disable iff (rst_in)
    !wk_active |=> wk_r == xcvr_mode_pkg::WK_IDLE) else $error("wake detector active");
  AST_FILTER_MIN: assert property (@(posedge clock_in) disable iff (rst_in)
    wk_r == xcvr_mode_pkg::WK_IDLE && wk_active && dom ##1 !dom |=> wk_r != xcvr_mode_pkg::WK_DONE)
    else $error("short pulse woke device");

  COV_NORMAL: cover property (@(posedge clock_in) mode_r == xcvr_mode_pkg::MODE_NORMAL);
  COV_STANDBY: cover property (@(posedge clock_in) mode_r == xcvr_mode_pkg::MODE_STANDBY);
  COV_WAKE_EVENT: cover property (@(posedge clock_in) wk_r == xcvr_mode_pkg::WK_DONE && !rxd_out);
  COV_TIMEOUT: cover property (@(posedge clock_in) timed_out && wk_r == xcvr_mode_pkg::WK_REC);
endmodule : can_transceiver_mode_wake_control

/* File: logic/xcvr_mode_pkg.sv */
package xcvr_mode_pkg;
  // mode encodings
  typedef enum logic [1:0] {
    MODE_UNPOWERED = 2'b00,
    MODE_WAKE = 2'b01,
    MODE_NORMAL = 2'b10,
    MODE_STANDBY = 2'b11
  } mode_e;

  // wake detector states
  typedef enum logic [2:0] {
    WK_IDLE = 3'b000,
    WK_DOM1 = 3'b001,
    WK_REC = 3'b010,
    WK_DOM2 = 3'b011,
    WK_DONE = 3'b100
  } wake_e;

  localparam int CLK_MHZ = 250;
  localparam int FILTER_NS = 500;
  localparam int FILTER_MAX_NS = 3600;
  localparam int TIMEOUT_US = 1000;
  localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam logic RXD_RECESSIVE = 1'b1;
  localparam logic RXD_DOMINANT = 1'b0;
endpackage : xcvr_mode_pkg

/* File: logic/phase_timer.sv */
`timescale 1ns/10ps
// counts cycles a level has held; restarts on every change
module phase_timer #(
  parameter int W = 20
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic level_in,
  input wire logic [W-1:0] limit_in,
  output logic reached_out
);
  logic level_r;
  logic [W-1:0] cnt_r;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      level_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      level_r <= level_in;
      if (clear_in || level_in != level_r) begin
        cnt_r <= '0;
      end else if (cnt_r != {W{1'b1}}) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reached_out <= 1'b0;
    end else begin
      reached_out <= !clear_in && level_in == level_r && cnt_r + {{(W-1){1'b0}}, 1'b1} >= limit_in;
    end
  end
endmodule : phase_timer

/* File: bench/can_controller_model.sv */
`timescale 1ns/10ps
// controller side: owns transmit data and standby select
module can_controller_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic follow_in,
  input wire logic standby_req_in,
  input wire logic txd_req_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic standby_select_out
);
  logic rxd_r;
  logic woke_r;

  // changes only at the falling edge, far from the sampling edge
  always_ff @(negedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rxd_r <= 1'b1;
      woke_r <= 1'b0;
    end else begin
      rxd_r <= rxd_in;
      if (!standby_req_in) begin
        woke_r <= 1'b0;
      end else if (follow_in && rxd_r && !rxd_in) begin
        woke_r <= 1'b1;
      end
    end
  end

  // a falling receive edge in standby drops the select to resume traffic
  assign standby_select_out = standby_req_in && !woke_r;
  assign txd_out = txd_req_in;
endmodule : can_controller_model

/* File: bench/can_transceiver_mode_wake_control_test.sv */
`timescale 1ns/10ps
module can_transceiver_mode_wake_control_test;
  localparam int TMO = 2000;
  logic clock_in, rst_in, mph, mpl, iph, ipl, uvh, uvl, bg, dom, follow, sreq, treq;
  logic [1:0] mode, mode_p;
  logic hiz, bhalf, bgnd, drv, ddom, hs, lp, wen, wev, rxd, wev_p, rxd_p, txd, standby_select;
  int n_errors = 0;
  int checked = 0;

  can_transceiver_mode_wake_control #(.PATTERN_WAKE(1'b0), .TIMEOUT_LIMIT(TMO))
  i_can_transceiver_mode_wake_control (.clock_in(clock_in), .rst_in(rst_in),
    .main_por_high_in(mph), .main_por_low_ok_in(mpl), .io_por_high_in(iph),
    .io_por_low_ok_in(ipl), .main_uv_high_in(uvh), .main_uv_low_ok_in(uvl),
    .bandgap_ok_in(bg), .txd_in(txd), .standby_select_in(standby_select), .bus_dominant_in(dom),
    .mode_out(mode), .bus_hiz_out(hiz), .bias_half_out(bhalf), .bias_ground_out(bgnd),
    .driver_en_out(drv), .drive_dominant_out(ddom), .hs_rx_en_out(hs),
    .lp_rx_en_out(lp), .wake_en_out(wen), .wake_event_out(wev), .rxd_out(rxd));
  // second variant shares every input; only its wake event, receive and mode outputs are judged
  can_transceiver_mode_wake_control #(.PATTERN_WAKE(1'b1), .TIMEOUT_LIMIT(TMO))
  i_can_transceiver_mode_wake_control_pattern (.clock_in(clock_in), .rst_in(rst_in),
    .main_por_high_in(mph), .main_por_low_ok_in(mpl), .io_por_high_in(iph),
    .io_por_low_ok_in(ipl), .main_uv_high_in(uvh), .main_uv_low_ok_in(uvl),
    .bandgap_ok_in(bg), .txd_in(txd), .standby_select_in(standby_select), .bus_dominant_in(dom),
    .mode_out(mode_p), .bus_hiz_out(), .bias_half_out(), .bias_ground_out(),
    .driver_en_out(), .drive_dominant_out(), .hs_rx_en_out(), .lp_rx_en_out(),
    .wake_en_out(), .wake_event_out(wev_p), .rxd_out(rxd_p));
  can_controller_model i_can_controller_model (.clock_in(clock_in), .rst_in(rst_in),
    .follow_in(follow), .standby_req_in(sreq), .txd_req_in(treq), .rxd_in(rxd),
    .txd_out(txd), .standby_select_out(standby_select));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask : step

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk

  task automatic end_of_test;
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  // eight cycles cover two sync flops, the mode register and the outputs
  task automatic test_power_up;
    chk({2'h0, mode}, 4'h0, "not unpowered at start");
    chk({hiz, bgnd, drv, wen}, 4'hC, "unpowered bus state");
    mph = 1'b1;
    mpl = 1'b1;
    step(8);
    chk({2'h0, mode}, 4'h0, "left unpowered with io supply low");
    iph = 1'b1;
    ipl = 1'b1;
    bg = 1'b1;
    dom = 1'b1;
    step(8);
    chk({2'h0, mode}, 4'h1, "no wake mode on both supplies");
    chk({hiz, bgnd, drv, rxd}, 4'hD, "wake mode outputs");
    uvh = 1'b1;
    uvl = 1'b1;
    step(8);
    chk({hiz, 1'b0, mode}, 4'h1, "normal entered with transmit low");
    treq = 1'b1;
    step(8);
    chk({2'h0, mode}, 4'h2, "no normal mode");
    chk({bhalf, drv, hs, bgnd}, 4'hE, "normal mode outputs");
    chk({3'h0, rxd}, 4'h0, "dominant not on receive");
    dom = 1'b0;
    treq = 1'b0;
    step(8);
    chk({2'h0, rxd, ddom}, 4'h3, "receive or drive wrong");
    treq = 1'b1;
    step(8);
  endtask : test_power_up

  task automatic test_undervoltage;
    dom = 1'b1;
    uvl = 1'b0;
    step(8);
    chk({hiz, rxd, mode}, 4'hD, "undervoltage not handled");
    uvl = 1'b1;
    step(8);
    chk({hiz, 1'b0, mode}, 4'h2, "no return to normal");
    bg = 1'b0;
    step(8);
    chk({drv, rxd, mode}, 4'h5, "bandgap loss kept normal");
    bg = 1'b1;
    dom = 1'b0;
    step(8);
  endtask : test_undervoltage

  task automatic test_basic_wake;
    int n;
    sreq = 1'b1;
    step(8);
    chk({2'h0, mode}, 4'h3, "no standby");
    chk({lp, wen, hs, drv}, 4'hC, "standby enables");
    chk({2'h0, bgnd, rxd}, 4'h3, "standby bias or receive");
    dom = 1'b1;
    step(60);
    dom = 1'b0;
    step(4);
    dom = 1'b1;
    step(100);
    chk({2'h0, wev, rxd}, 4'h1, "wake on split dominant");
    n = 0;
    while (rxd !== 1'b0 && n < 900) begin
      step(1);
      n++;
    end
    step(4);
    chk({2'h0, wev, rxd}, 4'h2, "no wake within filter limit");
    chk({3'h0, wev_p}, 4'h0, "pattern variant woke on one phase");
    dom = 1'b0;
    step(8);
    chk({3'h0, rxd}, 4'h1, "low-power receive not passing data");
    follow = 1'b1;
    dom = 1'b1;
    step(12);
    chk({2'h0, mode}, 4'h2, "standby select low not honoured");
    chk({3'h0, wev}, 4'h0, "wake event outlived standby");
    follow = 1'b0;
    sreq = 1'b0;
    dom = 1'b0;
    step(8);
  endtask : test_basic_wake

  task automatic test_pattern_wake;
    sreq = 1'b1;
    step(8);
    dom = 1'b1;
    step(140);
    dom = 1'b0;
    step(TMO);
    dom = 1'b1;
    step(140);
    chk({3'h0, wev_p}, 4'h0, "pattern survived timeout");
    dom = 1'b0;
    step(140);
    dom = 1'b1;
    step(140);
    chk({2'h0, wev_p, rxd_p}, 4'h2, "full pattern not detected");
    dom = 1'b0;
    sreq = 1'b0;
    step(12);
    chk({2'h0, mode_p}, 4'h2, "pattern variant kept standby");
  endtask : test_pattern_wake

  task automatic test_supply_loss;
    sreq = 1'b1;
    step(8);
    ipl = 1'b0;
    dom = 1'b1;
    step(200);
    chk({hiz, rxd, mode}, 4'hC, "io loss not unpowered");
    chk({3'h0, wev}, 4'h0, "wake seen without supplies");
    ipl = 1'b1;
    dom = 1'b0;
    step(10);
    chk({2'h0, mode}, 4'h3, "no recovery into standby");
    mpl = 1'b0;
    step(8);
    chk({2'h0, mode}, 4'h0, "main loss not unpowered");
    mpl = 1'b1;
    step(10);
    rst_in = 1'b1;
    step(2);
    chk({1'b0, hiz, mode}, 4'h4, "reset not unpowered");
  endtask : test_supply_loss

  initial begin
    rst_in = 1'b1;
    {mph, mpl, iph, ipl, uvh, uvl, bg, dom, follow, sreq, treq} = 11'h000;
    step(5);
    rst_in = 1'b0;
    step(2);
    test_power_up();
    test_undervoltage();
    test_basic_wake();
    test_pattern_wake();
    test_supply_loss();
    end_of_test();
  end

  // whole run is a few thousand cycles; this is far beyond it
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule : can_transceiver_mode_wake_control_test
